/* File: core/lcsc_consts.svh */
`ifndef LCSC_CONSTS_SVH
`define LCSC_CONSTS_SVH

// Register byte offsets on the register bus
`define LCSC_SET_OFS 8'hE0
`define LCSC_CLR_OFS 8'hE4

// Control field positions
`define LCSC_BIT_EXT_SEL 22
`define LCSC_BIT_MASTER 21
`define LCSC_BIT_RUN 20
`define LCSC_BIT_ACC_PHY 10
`define LCSC_BIT_ACC_SID 9

// Implemented bits; everything else reads as zero
`define LCSC_DEF_MASK 32'h0070_0600
`define LCSC_RST_VAL 32'h0000_0000

// Cycle period and timer tick rate
`define LCSC_CYC_PERIOD_US 125
`define LCSC_TICK_KHZ 24576
`define LCSC_ROLL_CNT ((`LCSC_CYC_PERIOD_US * `LCSC_TICK_KHZ) / 1000)

`endif

/* File: core/lcsc_pkg.sv */
package lcsc_pkg;

    typedef logic [11:0] lcsc_ofs_t;

    // Received cycle start: valid strobe with the sender's cycle offset
    typedef struct packed {
        logic valid;
        lcsc_ofs_t ofs;
    } lcsc_cyc_pkt_s;

    typedef struct packed {
        logic ext_sel;
        logic master;
        logic run;
        logic acc_phy;
        logic acc_sid;
    } lcsc_ctl_s;

    typedef struct packed {
        lcsc_ctl_s ctl;
        logic ext_d;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic send;
        logic phy_acc;
        logic sid_acc;
    } lcsc_main_s;

    typedef struct packed {
        lcsc_ofs_t ofs;
        logic roll;
    } lcsc_tmr_s;

endpackage

/* File: core/lcsc_cyc_timer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lcsc_consts.svh"

module lcsc_cyc_timer
    import lcsc_pkg::*;
#(
    parameter int unsigned ROLL_CNT = `LCSC_ROLL_CNT
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Control
    input wire logic tick,
    input wire logic run,
    input wire logic ext_sel,
    input wire logic ext_edge,
    input wire lcsc_cyc_pkt_s load,
    // Status
    output logic [11:0] o_ofs,
    output logic o_roll
);

    localparam lcsc_ofs_t LAST = lcsc_ofs_t'(ROLL_CNT - 1);

    lcsc_tmr_s cur_ff;
    lcsc_tmr_s nxt_tmr;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_tmr = cur_ff;
        nxt_tmr.roll = 1'b0;
        if (load.valid) begin
            nxt_tmr.ofs = load.ofs;
        end else if (run) begin
            if (ext_sel) begin
                if (ext_edge) begin
                    nxt_tmr.ofs = '0;
                    nxt_tmr.roll = 1'b1;
                end else if (tick && cur_ff.ofs != LAST) begin
                    nxt_tmr.ofs = cur_ff.ofs + 12'h001;
                end
            end else if (tick) begin
                if (cur_ff.ofs == LAST) begin
                    nxt_tmr.ofs = '0;
                    nxt_tmr.roll = 1'b1;
                end else begin
                    nxt_tmr.ofs = cur_ff.ofs + 12'h001;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '0;
        end else if (ce) begin
            cur_ff <= nxt_tmr;
        end
    end

    assign o_ofs = cur_ff.ofs;
    assign o_roll = cur_ff.roll;

    ////////////////////////////////////////////////////////////////////////////
    default clocking tmr_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    int_roll_a: assert property (
        ce && run && !ext_sel && !load.valid && tick && cur_ff.ofs == LAST
        |=> cur_ff.ofs == 12'h000 && cur_ff.roll)
        else $error("internal rollover missed at count limit");

    int_count_a: assert property (
        ce && run && !ext_sel && !load.valid && tick && cur_ff.ofs != LAST
        |=> cur_ff.ofs == lcsc_ofs_t'($past(cur_ff.ofs) + 12'h001) && !cur_ff.roll)
        else $error("offset did not advance on tick");

    ext_roll_a: assert property (
        ce && run && ext_sel && !load.valid && ext_edge
        |=> cur_ff.ofs == 12'h000 && cur_ff.roll)
        else $error("external rollover missed");

    ext_no_int_a: assert property (
        ce && ext_sel && !ext_edge |=> !cur_ff.roll)
        else $error("internal rollover while external source selected");

    hold_stop_a: assert property (
        ce && !run && !load.valid |=> $stable(cur_ff.ofs) && !cur_ff.roll)
        else $error("offset moved while timer stopped");

    ext_roll_c: cover property (ce && run && ext_sel && ext_edge);

endmodule // lcsc_cyc_timer

`default_nettype wire

/* File: core/lcsc_link_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lcsc_consts.svh"

module lcsc_link_ctrl
    import lcsc_pkg::*;
#(
    parameter int unsigned ADDR_W = 8,
    parameter int unsigned ROLL_CNT = `LCSC_ROLL_CNT
) (
    // Clock, reset, enable
    input wire logic I_CLK_SYS,
    input wire logic I_RST_B,
    input wire logic I_CE,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Cycle timer
    input wire logic I_CYC_TICK,
    input wire logic I_EXTERNAL_CYCLE_INPUT,
    input wire logic I_PHY_ROOT,
    input wire lcsc_cyc_pkt_s I_CYC_START_RCV,
    input wire logic I_CYCLE_OVERRUN_EVENT,
    input wire logic I_OVERRUN_FLAG,
    output logic O_CYCLE_START_SEND,
    output logic [11:0] O_CYCLE_OFFSET,
    // Receiver
    input wire logic I_ASYNC_RECEIVE_CTX_EN,
    input wire logic I_PHY_PKT_VALID,
    input wire logic I_SELF_ID_VALID,
    output logic O_PHY_PKT_ACCEPT,
    output logic O_SELF_ID_ACCEPT
);

    localparam logic [ADDR_W-1:0] SET_ADR = ADDR_W'(`LCSC_SET_OFS);
    localparam logic [ADDR_W-1:0] CLR_ADR = ADDR_W'(`LCSC_CLR_OFS);
    localparam logic [31:0] DEF_MASK = `LCSC_DEF_MASK;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    lcsc_main_s cur_ff;
    lcsc_main_s nxt_st;
    lcsc_cyc_pkt_s tmr_load;
    logic [11:0] tmr_ofs;
    logic tmr_roll;
    logic hit_set;
    logic hit_clr;
    logic hit;
    logic setup;
    logic wr_acc;
    logic ext_edge;
    logic [31:0] ctl_word;
    logic [31:0] set_v;
    logic [31:0] clr_v;

    always_comb begin
        ctl_word = `LCSC_RST_VAL;
        ctl_word[`LCSC_BIT_EXT_SEL] = cur_ff.ctl.ext_sel;
        ctl_word[`LCSC_BIT_MASTER] = cur_ff.ctl.master;
        ctl_word[`LCSC_BIT_RUN] = cur_ff.ctl.run;
        ctl_word[`LCSC_BIT_ACC_PHY] = cur_ff.ctl.acc_phy;
        ctl_word[`LCSC_BIT_ACC_SID] = cur_ff.ctl.acc_sid;
    end

    assign hit_set = (I_PADDR == SET_ADR);
    assign hit_clr = (I_PADDR == CLR_ADR);
    assign hit = hit_set | hit_clr;
    assign setup = I_PSEL & ~I_PENABLE;
    assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE & cur_ff.pready;
    assign set_v = (wr_acc && hit_set) ? I_PWDATA : 32'h0000_0000;
    assign clr_v = (wr_acc && hit_clr) ? I_PWDATA : 32'h0000_0000;
    assign ext_edge = I_EXTERNAL_CYCLE_INPUT & ~cur_ff.ext_d;

    always_comb begin
        tmr_load.valid = I_CYC_START_RCV.valid & ~cur_ff.ctl.master;
        tmr_load.ofs = I_CYC_START_RCV.ofs;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = cur_ff;
        nxt_st.ext_d = I_EXTERNAL_CYCLE_INPUT;
        // zero wait read of either address
        nxt_st.pready = setup;
        nxt_st.pslverr = setup & ~hit;
        if (setup) begin
            nxt_st.prdata = hit ? ctl_word : 32'h0000_0000;
        end
        nxt_st.ctl.ext_sel = (cur_ff.ctl.ext_sel | set_v[`LCSC_BIT_EXT_SEL])
            & ~clr_v[`LCSC_BIT_EXT_SEL];
        nxt_st.ctl.run = (cur_ff.ctl.run | set_v[`LCSC_BIT_RUN])
            & ~clr_v[`LCSC_BIT_RUN];
        nxt_st.ctl.acc_phy = (cur_ff.ctl.acc_phy | set_v[`LCSC_BIT_ACC_PHY])
            & ~clr_v[`LCSC_BIT_ACC_PHY];
        nxt_st.ctl.acc_sid = (cur_ff.ctl.acc_sid | set_v[`LCSC_BIT_ACC_SID])
            & ~clr_v[`LCSC_BIT_ACC_SID];
        if (I_CYCLE_OVERRUN_EVENT) begin
            nxt_st.ctl.master = 1'b0;
        end else if (set_v[`LCSC_BIT_MASTER] && !I_OVERRUN_FLAG) begin
            nxt_st.ctl.master = 1'b1;
        end else if (clr_v[`LCSC_BIT_MASTER]) begin
            nxt_st.ctl.master = 1'b0;
        end
        // cycle start on rollover as root master
        nxt_st.send = tmr_roll & cur_ff.ctl.master & I_PHY_ROOT;
        // PHY packets into async receive context
        nxt_st.phy_acc = I_PHY_PKT_VALID & cur_ff.ctl.acc_phy & I_ASYNC_RECEIVE_CTX_EN;
        // self-id independent of PHY packet enable
        // self-id gated by its own enable
        nxt_st.sid_acc = I_SELF_ID_VALID & cur_ff.ctl.acc_sid;
    end

    always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '0;
        end else if (I_CE) begin
            cur_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cycle offset counter
    lcsc_cyc_timer #(
        .ROLL_CNT(ROLL_CNT)
    ) u_cyc_timer (
        .clk(I_CLK_SYS),
        .rst_n(rst_n),
        .ce(I_CE),
        .tick(I_CYC_TICK),
        .run(cur_ff.ctl.run),
        .ext_sel(cur_ff.ctl.ext_sel),
        .ext_edge(ext_edge),
        .load(tmr_load),
        .o_ofs(tmr_ofs),
        .o_roll(tmr_roll)
    );

    assign O_PRDATA = cur_ff.prdata;
    assign O_PREADY = cur_ff.pready;
    assign O_PSLVERR = cur_ff.pslverr;
    assign O_CYCLE_START_SEND = cur_ff.send;
    assign O_CYCLE_OFFSET = tmr_ofs;
    assign O_PHY_PKT_ACCEPT = cur_ff.phy_acc;
    assign O_SELF_ID_ACCEPT = cur_ff.sid_acc;

    ////////////////////////////////////////////////////////////////////////////
    default clocking main_cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!rst_n);

    rsvd_zero_a: assert property (
        O_PREADY |-> (O_PRDATA & ~DEF_MASK) == 32'h0000_0000)
        else $error("reserved bits read as nonzero");

    read_both_a: assert property (
        I_CE && setup && hit |=> O_PREADY && !O_PSLVERR && O_PRDATA == $past(ctl_word))
        else $error("read did not return control value");

    unmapped_a: assert property (
        I_CE && setup && !hit |=> O_PREADY && O_PSLVERR && O_PRDATA == 32'h0000_0000)
        else $error("unmapped access not flagged");

    set_write_a: assert property (
        I_CE && wr_acc && hit_set && !I_CYCLE_OVERRUN_EVENT && !I_OVERRUN_FLAG
        |=> ctl_word == ($past(ctl_word) | ($past(I_PWDATA) & DEF_MASK)))
        else $error("set write gave wrong value");

    clr_write_a: assert property (
        I_CE && wr_acc && hit_clr && !I_CYCLE_OVERRUN_EVENT
        |=> ctl_word == ($past(ctl_word) & ~$past(I_PWDATA)))
        else $error("clear write gave wrong value");

    overrun_clr_a: assert property (
        I_CE && I_CYCLE_OVERRUN_EVENT |=> !cur_ff.ctl.master)
        else $error("overrun did not clear master");

    set_block_a: assert property (
        I_CE && I_OVERRUN_FLAG && !cur_ff.ctl.master |=> !cur_ff.ctl.master)
        else $error("master set while overrun flag up");

    send_roll_a: assert property (
        I_CE && tmr_roll |=> O_CYCLE_START_SEND == $past(cur_ff.ctl.master && I_PHY_ROOT))
        else $error("cycle start send wrong at rollover");

    slave_load_a: assert property (
        I_CE && I_CYC_START_RCV.valid && !cur_ff.ctl.master
        |=> tmr_ofs == $past(I_CYC_START_RCV.ofs))
        else $error("received cycle start not loaded");

    phy_acc_a: assert property (
        I_CE |=> O_PHY_PKT_ACCEPT == $past(I_PHY_PKT_VALID && cur_ff.ctl.acc_phy
            && I_ASYNC_RECEIVE_CTX_EN))
        else $error("PHY packet acceptance wrong");

    sid_acc_a: assert property (
        I_CE |=> O_SELF_ID_ACCEPT == $past(I_SELF_ID_VALID && cur_ff.ctl.acc_sid))
        else $error("self-id acceptance wrong");

    reset_zero_a: assert property (
        $rose(rst_n) |-> ctl_word == `LCSC_RST_VAL && !O_PREADY)
        else $error("control not zero after reset");

    send_only_roll_a: assert property (
        I_CE && !tmr_roll
        |=> !O_CYCLE_START_SEND)
        else $error("cycle start sent without rollover");

    send_root_gate_a: assert property (
        I_CE && !I_PHY_ROOT
        |=> !O_CYCLE_START_SEND)
        else $error("cycle start sent while not root");

    send_master_gate_a: assert property (
        I_CE && !cur_ff.ctl.master
        |=> !O_CYCLE_START_SEND)
        else $error("cycle start sent while not master");

    master_no_sync_a: assert property (
        I_CE && I_CYC_START_RCV.valid && cur_ff.ctl.master && !cur_ff.ctl.run
        |=> $stable(tmr_ofs))
        else $error("master took a received cycle start");

    run_hold_a: assert property (
        I_CE && !cur_ff.ctl.run && !tmr_load.valid
        |=> $stable(tmr_ofs))
        else $error("offset moved with run bit clear");

    limit_roll_a: assert property (
        I_CE && cur_ff.ctl.run && !cur_ff.ctl.ext_sel && !tmr_load.valid && I_CYC_TICK
            && tmr_ofs == lcsc_ofs_t'(ROLL_CNT - 1)
        |=> tmr_ofs == 12'h000)
        else $error("offset did not wrap at count limit");

    ext_edge_roll_a: assert property (
        I_CE && cur_ff.ctl.run && cur_ff.ctl.ext_sel && !tmr_load.valid && ext_edge
        |=> tmr_ofs == 12'h000)
        else $error("offset did not wrap on external edge");

    ctx_gate_a: assert property (
        I_CE && !I_ASYNC_RECEIVE_CTX_EN
        |=> !O_PHY_PKT_ACCEPT)
        else $error("PHY packet accepted with context off");

    phy_en_gate_a: assert property (
        I_CE && !cur_ff.ctl.acc_phy
        |=> !O_PHY_PKT_ACCEPT)
        else $error("PHY packet accepted with enable clear");

    sid_indep_a: assert property (
        I_CE && I_SELF_ID_VALID && cur_ff.ctl.acc_sid && !cur_ff.ctl.acc_phy
        |=> O_SELF_ID_ACCEPT)
        else $error("self-id refused with PHY enable clear");

    sid_gate_a: assert property (
        I_CE && !cur_ff.ctl.acc_sid
        |=> !O_SELF_ID_ACCEPT)
        else $error("self-id accepted with enable clear");

    set_master_a: assert property (
        I_CE && wr_acc && hit_set && I_PWDATA[`LCSC_BIT_MASTER] && !I_OVERRUN_FLAG
            && !I_CYCLE_OVERRUN_EVENT
        |=> cur_ff.ctl.master)
        else $error("master not set by set write");

    clr_master_a: assert property (
        I_CE && wr_acc && hit_clr && I_PWDATA[`LCSC_BIT_MASTER]
        |=> !cur_ff.ctl.master)
        else $error("master not cleared by clear write");

    no_stray_a: assert property (
        I_CE && !wr_acc && !I_CYCLE_OVERRUN_EVENT
        |=> $stable(ctl_word))
        else $error("control changed without a write");

    unmapped_keep_a: assert property (
        I_CE && wr_acc && !hit && !I_CYCLE_OVERRUN_EVENT
        |=> $stable(ctl_word))
        else $error("unmapped write changed control");

    err_ready_a: assert property (
        O_PSLVERR |-> O_PREADY)
        else $error("error flag without ready");

    ready_pulse_a: assert property (
        I_CE && O_PREADY
        |=> !O_PREADY)
        else $error("ready held past the access cycle");

    rdata_hold_a: assert property (
        I_CE && !setup
        |=> $stable(O_PRDATA))
        else $error("read data changed outside setup");

    ce_hold_a: assert property (
        !I_CE
        |=> $stable(ctl_word) && $stable(tmr_ofs) && $stable(O_PREADY))
        else $error("state moved while clock enable low");

    set_wr_c: cover property (I_CE && wr_acc && hit_set);
    send_c: cover property (O_CYCLE_START_SEND);
    resync_c: cover property (I_CE && tmr_load.valid);
    phy_acc_c: cover property (O_PHY_PKT_ACCEPT);

endmodule // lcsc_link_ctrl

`default_nettype wire

/* File: tb/lcsc_phy_model.sv */
`timescale 1ns/100ps
`default_nettype none

module lcsc_phy_model
    import lcsc_pkg::*;
(
    // Clock
    input wire logic clk,
    // PHY side
    output logic o_tick,
    output logic o_ext,
    output lcsc_cyc_pkt_s o_pkt
);
    initial begin
        o_tick = 1'b0;
        o_ext = 1'b0;
        o_pkt = '0;
    end

    // One tick per 24.576 MHz period, about ten system clocks
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk) o_tick <= 1'b1;
            @(posedge clk) o_tick <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask

    task automatic ext_edge();
        @(posedge clk) o_ext <= 1'b1;
        repeat (4) @(posedge clk);
        o_ext <= 1'b0;
    endtask

    // Offset is scrambled once the packet is gone
    task automatic cyc_start(input lcsc_ofs_t ofs);
        @(posedge clk) o_pkt <= {1'b1, ofs};
        @(posedge clk) o_pkt <= {1'b0, ~ofs};
    endtask
endmodule // lcsc_phy_model

`default_nettype wire

/* File: tb/link_control_set_clear_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module link_control_set_clear_bench
    import lcsc_pkg::*;
;
    logic clk, rst_b, ce, psel, pen, pwr, root, ov, flag, ctx, pv, sv;
    logic [7:0] padr;
    logic [31:0] pwd, rd, prdata;
    logic er, pready, pslverr, send, pacc, sacc, tick, ext;
    logic [11:0] ofs;
    lcsc_cyc_pkt_s pkt;
    int failures, compares, sends;

    lcsc_phy_model u_lcsc_phy_model (.clk(clk), .o_tick(tick), .o_ext(ext), .o_pkt(pkt));

    lcsc_link_ctrl #(.ROLL_CNT(8)) u_lcsc_link_ctrl (
        .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_CE(ce),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr),
        .I_PWDATA(pwd), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_CYC_TICK(tick), .I_EXTERNAL_CYCLE_INPUT(ext), .I_PHY_ROOT(root),
        .I_CYC_START_RCV(pkt), .I_CYCLE_OVERRUN_EVENT(ov), .I_OVERRUN_FLAG(flag),
        .O_CYCLE_START_SEND(send), .O_CYCLE_OFFSET(ofs),
        .I_ASYNC_RECEIVE_CTX_EN(ctx), .I_PHY_PKT_VALID(pv), .I_SELF_ID_VALID(sv),
        .O_PHY_PKT_ACCEPT(pacc), .O_SELF_ID_ACCEPT(sacc));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        if (send === 1'b1) sends <= sends + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk) begin
            psel <= 1'b1;
            pen <= 1'b0;
            pwr <= wr;
            padr <= a;
            pwd <= d;
        end
        @(posedge clk) pen <= 1'b1;
        // Reads right after the edge see what the slave presented at that edge
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) begin
            failures++;
            stop_test();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rchk(8'hE0, 32'h0, "reset set port");
        rchk(8'hE4, 32'h0, "reset clear port");
        apb(1'b1, 8'hE0, 32'hFFFFFFFF);
        rchk(8'hE0, 32'h00700600, "set all");
        rchk(8'hE4, 32'h00700600, "clear port read");
        apb(1'b1, 8'hE4, 32'h00000400);
        rchk(8'hE0, 32'h00700200, "clear one");
        apb(1'b1, 8'hE0, 32'h0);
        rchk(8'hE4, 32'h00700200, "set zero");
        apb(1'b1, 8'hE4, 32'hFFFFFFFF);
        apb(1'b1, 8'hE8, 32'hFFFFFFFF);
        rchk(8'hE8, 32'h0, "unmapped data");
        chk("unmapped err", 32'h1, {31'h0, er});
        rchk(8'hE0, 32'h0, "clear all");
        $display("test regs done");
    endtask

    task automatic t_master();
        flag <= 1'b1;
        apb(1'b1, 8'hE0, 32'h00200000);
        rchk(8'hE0, 32'h0, "master blocked");
        flag <= 1'b0;
        apb(1'b1, 8'hE0, 32'h00200000);
        rchk(8'hE0, 32'h00200000, "master set");
        @(posedge clk) ov <= 1'b1;
        @(posedge clk) ov <= 1'b0;
        rchk(8'hE0, 32'h0, "overrun clears");
        $display("test master done");
    endtask

    task automatic t_timer();
        int s0;
        root <= 1'b1;
        apb(1'b1, 8'hE0, 32'h00300000);
        u_lcsc_phy_model.ticks(3);
        settle();
        chk("offset 3", 32'd3, {20'h0, ofs});
        s0 = sends;
        u_lcsc_phy_model.ticks(5);
        settle();
        chk("rollover", 32'd0, {20'h0, ofs});
        chk("sent at roll", s0 + 1, sends);
        root <= 1'b0;
        u_lcsc_phy_model.ticks(8);
        settle();
        chk("no send unrooted", s0 + 1, sends);
        apb(1'b1, 8'hE4, 32'h00100000);
        u_lcsc_phy_model.ticks(3);
        settle();
        chk("offset holds", 32'd0, {20'h0, ofs});
        apb(1'b1, 8'hE4, 32'h00200000);
        $display("test timer done");
    endtask

    task automatic t_ext();
        apb(1'b1, 8'hE0, 32'h00500000);
        u_lcsc_phy_model.ticks(12);
        settle();
        chk("ext saturate", 32'd7, {20'h0, ofs});
        u_lcsc_phy_model.ext_edge();
        settle();
        chk("ext roll", 32'd0, {20'h0, ofs});
        apb(1'b1, 8'hE4, 32'h00500000);
        $display("test ext done");
    endtask

    task automatic t_sync();
        u_lcsc_phy_model.cyc_start(12'd5);
        settle();
        chk("sync load", 32'd5, {20'h0, ofs});
        apb(1'b1, 8'hE0, 32'h00200000);
        u_lcsc_phy_model.cyc_start(12'd9);
        settle();
        chk("master ignores", 32'd5, {20'h0, ofs});
        apb(1'b1, 8'hE4, 32'h00200000);
        $display("test sync done");
    endtask

    task automatic t_ce();
        apb(1'b1, 8'hE0, 32'h00100000);
        ce <= 1'b0;
        u_lcsc_phy_model.ticks(3);
        settle();
        chk("frozen offset", 32'd5, {20'h0, ofs});
        @(posedge clk) ce <= 1'b1;
        u_lcsc_phy_model.ticks(2);
        settle();
        chk("resumed offset", 32'd7, {20'h0, ofs});
        apb(1'b1, 8'hE4, 32'h00100000);
        $display("test ce done");
    endtask

    task automatic t_rcv();
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            // no pointer register here; software order assumed
            apb(1'b1, 8'hE0, {21'h0, c[0], c[1], 9'h0});
            ctx <= c[2];
            @(posedge clk) begin
                pv <= 1'b1;
                sv <= 1'b1;
            end
            @(posedge clk) begin
                pv <= 1'b0;
                sv <= 1'b0;
            end
            @(negedge clk);
            chk("phy accept", {31'h0, c[0] & c[2]}, {31'h0, pacc});
            chk("self id accept", {31'h0, c[1]}, {31'h0, sacc});
            apb(1'b1, 8'hE4, 32'h00000600);
        end
        $display("test rcv done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, psel, pen, pwr, root, ov, flag, ctx, pv, sv} = '0;
        ce = 1'b1;
        padr = 8'h0;
        pwd = 32'h0;
        failures = 0;
        compares = 0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_master();
        t_timer();
        t_ext();
        t_sync();
        t_ce();
        t_rcv();
        stop_test();
    end
endmodule // link_control_set_clear_bench

`default_nettype wire
